// File: rtl/bfs_consts.vh
// Constants shared by the burst-of-four SRAM port design files.
`ifndef BFS_CONSTS_VH
`define BFS_CONSTS_VH

// Organisation selected when none is given (data lines per port).
`define BFS_ORG_DEFAULT   36
// Fixed burst length of every access, in words.
`define BFS_BURST_LEN     4
// Lane widths governed by one write mask.
`define BFS_NIBBLE_W      4
`define BFS_BYTE_W        9
// Address widths per organisation.
`define BFS_AW_WIDE       20
`define BFS_AW_NARROW     19
// Burst word address field: position and width inside the address.
`define BFS_BWA_LSB       0
`define BFS_BWA_W         2
// Time both output clocks must stay high before single clock mode is taken.
`define BFS_MCLK_NS       25
`define BFS_SINGLE_HOLD_NS 200
`define BFS_SINGLE_HOLD   ((`BFS_SINGLE_HOLD_NS + `BFS_MCLK_NS - 1) / `BFS_MCLK_NS)
// Reset values of the echo clock pair.
`define BFS_ECHO_P_RST    1'b0
`define BFS_ECHO_N_RST    1'b1

`endif

// File: rtl/bfs_sync.v
// Two flip-flop synchroniser for a vector of asynchronous inputs.
`timescale 1ns/1ps
module bfs_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] din,
   output wire [W-1:0] dout
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // The first stage is read only by the second stage.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule // bfs_sync

// File: rtl/bfs_mem.v
// Storage array of wide burst words with bit write enables and registered read.
`timescale 1ns/1ps
module bfs_mem #(
   parameter AW = 4,
   parameter W  = 8
) (
   input  wire          clk,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [W-1:0]  wdata,
   input  wire [W-1:0]  wbe,
   input  wire          re,
   input  wire [AW-1:0] raddr,
   output wire [W-1:0]  rdata
);
   reg [W-1:0] mem [0:(1<<AW)-1];
   reg [W-1:0] rdata_q;
   integer     i;

   // Only enabled bits change, so masked lanes keep their old contents.
   always @(posedge clk) begin
      if (we) begin
         for (i = 0; i < W; i = i + 1) begin
            if (wbe[i]) begin
               mem[waddr][i] <= wdata[i];
            end
         end
      end
      if (re) begin
         rdata_q <= mem[raddr];
      end
   end

   assign rdata = rdata_q;
endmodule // bfs_mem

// File: rtl/bfs_port.v
// Burst-of-four double data rate SRAM port: command, write capture, read launch, echo clocks.
`timescale 1ns/1ps
`include "bfs_consts.vh"
module bfs_port #(
   parameter ORG    = `BFS_ORG_DEFAULT,
   parameter ROW_AW = (ORG >= 18) ? (((ORG == 18) ? `BFS_AW_WIDE : `BFS_AW_NARROW) - `BFS_BWA_W)
                                  : `BFS_AW_NARROW
) (
   input  wire                                          mclk,
   input  wire                                          rstn,
   input  wire                                          input_clk_p,
   input  wire                                          input_clk_n,
   input  wire                                          output_clk_p,
   input  wire                                          output_clk_n,
   input  wire                                          dll_off_n,
   input  wire                                          load_n,
   input  wire                                          read_not_write,
   input  wire [((ORG==18)?`BFS_AW_WIDE:`BFS_AW_NARROW)-1:0] addr_in,
   input  wire [((ORG==8)?2:(ORG==9)?1:(ORG==18)?2:4)-1:0]   byte_mask_n,
   input  wire [ORG-1:0]                                data_in,
   output wire [ORG-1:0]                                data_out,
   output wire                                          data_oe,
   output wire                                          echo_clk_p,
   output wire                                          echo_clk_n
);
   // Organisation dependent geometry.
   localparam DW      = ORG;
   localparam AW      = (ORG == 18) ? `BFS_AW_WIDE : `BFS_AW_NARROW;
   localparam MW      = (ORG == 8) ? 2 : (ORG == 9) ? 1 : (ORG == 18) ? 2 : 4;
   localparam LANE    = (ORG == 8) ? `BFS_NIBBLE_W : `BFS_BYTE_W;
   localparam HAS_BWA = (ORG >= 18) ? 1 : 0;
   localparam RA_LSB  = HAS_BWA ? `BFS_BWA_W : 0;
   localparam WW      = `BFS_BURST_LEN * DW;
   localparam SW      = 7 + AW + MW + DW;
   localparam HOLD    = `BFS_SINGLE_HOLD;

   // Burst slot of a beat: linear order with wrap inside the four words.
   function [1:0] bfs_slot;
      input [1:0] start;
      input [1:0] beat;
      reg   [2:0] sum;
      begin
         sum      = {1'b0, start} + {1'b0, beat};
         bfs_slot = sum[1:0];
      end
   endfunction

   // Expands active-low lane masks into active-high bit enables.
   function [DW-1:0] bfs_lane_en;
      input [MW-1:0] m_n;
      integer i;
      begin
         bfs_lane_en = {DW{1'b0}};
         for (i = 0; i < DW; i = i + 1) begin
            bfs_lane_en[i] = ~m_n[i / LANE];
         end
      end
   endfunction

   reg            rst_a_q;
   reg            rst_n_q;
   wire [SW-1:0]  sync_o;
   wire           kp_s;
   wire           kn_s;
   wire           cp_s;
   wire           cn_s;
   wire           dll_off_n_s;
   wire           load_n_s;
   wire           rnw_s;
   wire [AW-1:0]  addr_s;
   wire [MW-1:0]  mask_s;
   wire [DW-1:0]  data_s;
   reg  [3:0]     prev_q;
   reg  [3:0]     hold_cnt_q;
   reg            single_q;
   reg            gap_q;
   reg            wp_v_q;
   reg  [ROW_AW-1:0] wp_row_q;
   reg  [1:0]     wp_start_q;
   reg            cap_act_q;
   reg  [1:0]     cap_beat_q;
   reg  [ROW_AW-1:0] cap_row_q;
   reg  [1:0]     cap_start_q;
   reg  [WW-1:0]  cap_data_q;
   reg  [WW-1:0]  cap_be_q;
   reg            cap_done_q;
   reg            rd_ld_q;
   reg  [1:0]     rd_st_q;
   reg            rq_v_q;
   reg  [WW-1:0]  rq_word_q;
   reg  [1:0]     rq_start_q;
   reg            ob_act_q;
   reg  [1:0]     ob_beat_q;
   reg  [WW-1:0]  ob_word_q;
   reg  [1:0]     ob_start_q;
   reg  [DW-1:0]  ob_dq_q;
   reg            ob_oe_q;
   reg  [DW-1:0]  dly_dq_q;
   reg            dly_oe_q;
   reg            echo_p_pre_q;
   reg            echo_n_pre_q;
   reg  [DW-1:0]  data_out_q;
   reg            data_oe_q;
   reg            echo_p_q;
   reg            echo_n_q;
   wire [WW-1:0]  mem_rdata;

   // Reset is asserted at once and released through two flip-flops.
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_a_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_n_q <= rst_a_q;
      end
   end

   // All pins but mclk and rstn, link clocks included, pass the same synchroniser so they stay aligned.
   bfs_sync #(.W(SW)) u_sync (
      .clk   (mclk),
      .rst_n (rst_n_q),
      .din   ({input_clk_p, input_clk_n, output_clk_p, output_clk_n, dll_off_n,
               load_n, read_not_write, addr_in, byte_mask_n, data_in}),
      .dout  (sync_o)
   );

   assign {kp_s, kn_s, cp_s, cn_s, dll_off_n_s, load_n_s, rnw_s,
           addr_s, mask_s, data_s} = sync_o;

   // Rising edges of the sampled link clocks.
   wire kp_rise = kp_s & ~prev_q[3];
   wire kn_rise = kn_s & ~prev_q[2];
   wire cp_rise = cp_s & ~prev_q[1];
   wire cn_rise = cn_s & ~prev_q[0];
   wire ap_rise = single_q ? kp_rise : cp_rise;
   wire an_rise = single_q ? kn_rise : cn_rise;

   // Command decode on input_clk_p; the edge after an accepted command is blind.
   wire           cmd_ok = kp_rise & ~load_n_s & ~gap_q;
   wire           rd_cmd = cmd_ok & rnw_s;
   wire           wr_cmd = cmd_ok & ~rnw_s;
   wire [1:0]     bwa    = HAS_BWA ? addr_s[`BFS_BWA_LSB +: `BFS_BWA_W] : 2'b00;
   wire [ROW_AW-1:0] row = addr_s[RA_LSB +: ROW_AW];
   wire [DW-1:0]  beat_en = bfs_lane_en(mask_s);

   // Edge history, single clock mode filter and command spacing.
   always @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         prev_q     <= 4'h0;
         hold_cnt_q <= 4'h0;
         single_q   <= 1'b0;
         gap_q      <= 1'b0;
      end else begin
         prev_q <= {kp_s, kn_s, cp_s, cn_s};
         // Both output clocks must stay high for a while, not just overlap.
         if (cp_s & cn_s) begin
            if (hold_cnt_q != HOLD[3:0]) begin
               hold_cnt_q <= hold_cnt_q + 4'h1;
            end
         end else begin
            hold_cnt_q <= 4'h0;
         end
         single_q <= (cp_s & cn_s) & (hold_cnt_q == HOLD[3:0]);
         if (kp_rise) begin
            gap_q <= cmd_ok;
         end
      end
   end

   // Write capture: the command waits in a pending slot until its first word.
   always @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wp_v_q      <= 1'b0;
         wp_row_q    <= {ROW_AW{1'b0}};
         wp_start_q  <= 2'b00;
         cap_act_q   <= 1'b0;
         cap_beat_q  <= 2'b00;
         cap_row_q   <= {ROW_AW{1'b0}};
         cap_start_q <= 2'b00;
         cap_data_q  <= {WW{1'b0}};
         cap_be_q    <= {WW{1'b0}};
         cap_done_q  <= 1'b0;
      end else begin
         cap_done_q <= 1'b0;
         if (kp_rise) begin
            if (cap_act_q && cap_beat_q == 2'd2) begin
               cap_data_q[bfs_slot(cap_start_q, 2'd2)*DW +: DW] <= data_s;
               cap_be_q[bfs_slot(cap_start_q, 2'd2)*DW +: DW]   <= beat_en;
               cap_beat_q <= 2'd3;
            end else if (!cap_act_q && wp_v_q) begin
               cap_row_q   <= wp_row_q;
               cap_start_q <= wp_start_q;
               cap_data_q[bfs_slot(wp_start_q, 2'd0)*DW +: DW] <= data_s;
               cap_be_q[bfs_slot(wp_start_q, 2'd0)*DW +: DW]   <= beat_en;
               cap_act_q  <= 1'b1;
               cap_beat_q <= 2'd1;
            end
            if (wr_cmd) begin
               wp_v_q     <= 1'b1;
               wp_row_q   <= row;
               wp_start_q <= bwa;
            end else if (!cap_act_q && wp_v_q) begin
               wp_v_q <= 1'b0;
            end
         end
         if (kn_rise && cap_act_q) begin
            if (cap_beat_q == 2'd1) begin
               cap_data_q[bfs_slot(cap_start_q, 2'd1)*DW +: DW] <= data_s;
               cap_be_q[bfs_slot(cap_start_q, 2'd1)*DW +: DW]   <= beat_en;
               cap_beat_q <= 2'd2;
            end else if (cap_beat_q == 2'd3) begin
               cap_data_q[bfs_slot(cap_start_q, 2'd3)*DW +: DW] <= data_s;
               cap_be_q[bfs_slot(cap_start_q, 2'd3)*DW +: DW]   <= beat_en;
               cap_act_q  <= 1'b0;
               cap_beat_q <= 2'd0;
               cap_done_q <= 1'b1;
            end
         end
      end
   end

   // Whole burst is written as one wide word; masked lanes keep old data.
   bfs_mem #(.AW(ROW_AW), .W(WW)) u_mem (
      .clk   (mclk),
      .we    (cap_done_q),
      .waddr (cap_row_q),
      .wdata (cap_data_q),
      .wbe   (cap_be_q),
      .re    (rd_cmd),
      .raddr (row),
      .rdata (mem_rdata)
   );

   // Read fetch: the wide word waits in a queue slot for the output sequencer.
   always @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_ld_q    <= 1'b0;
         rd_st_q    <= 2'b00;
         rq_v_q     <= 1'b0;
         rq_word_q  <= {WW{1'b0}};
         rq_start_q <= 2'b00;
      end else begin
         rd_ld_q <= rd_cmd;
         if (rd_cmd) begin
            rd_st_q <= bwa;
         end
         if (rd_ld_q) begin
            rq_v_q     <= 1'b1;
            rq_word_q  <= mem_rdata;
            rq_start_q <= rd_st_q;
         end else if (ap_rise && rq_v_q && (!ob_act_q || ob_beat_q == 2'd0)) begin
            rq_v_q <= 1'b0;
         end
      end
   end

   // Output sequencer: p edge, n edge, p edge, n edge, then drivers off.
   always @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ob_act_q     <= 1'b0;
         ob_beat_q    <= 2'd0;
         ob_word_q    <= {WW{1'b0}};
         ob_start_q   <= 2'b00;
         ob_dq_q      <= {DW{1'b0}};
         ob_oe_q      <= 1'b0;
         echo_p_pre_q <= `BFS_ECHO_P_RST;
         echo_n_pre_q <= `BFS_ECHO_N_RST;
      end else begin
         if (ap_rise) begin
            echo_p_pre_q <= 1'b1;
            echo_n_pre_q <= 1'b0;
            if (ob_act_q && ob_beat_q == 2'd2) begin
               ob_dq_q   <= ob_word_q[bfs_slot(ob_start_q, 2'd2)*DW +: DW];
               ob_beat_q <= 2'd3;
            end else if (rq_v_q) begin
               ob_word_q  <= rq_word_q;
               ob_start_q <= rq_start_q;
               ob_dq_q    <= rq_word_q[bfs_slot(rq_start_q, 2'd0)*DW +: DW];
               ob_oe_q    <= 1'b1;
               ob_act_q   <= 1'b1;
               ob_beat_q  <= 2'd1;
            end else begin
               ob_oe_q   <= 1'b0;
               ob_act_q  <= 1'b0;
               ob_beat_q <= 2'd0;
            end
         end else if (an_rise) begin
            echo_p_pre_q <= 1'b0;
            echo_n_pre_q <= 1'b1;
            if (ob_act_q && ob_beat_q == 2'd1) begin
               ob_dq_q   <= ob_word_q[bfs_slot(ob_start_q, 2'd1)*DW +: DW];
               ob_beat_q <= 2'd2;
            end else if (ob_act_q && ob_beat_q == 2'd3) begin
               ob_dq_q   <= ob_word_q[bfs_slot(ob_start_q, 2'd3)*DW +: DW];
               ob_beat_q <= 2'd0;
            end
         end
      end
   end

   // Output registers; with the loop bypassed data lags its clock by one stage.
   always @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         dly_dq_q   <= {DW{1'b0}};
         dly_oe_q   <= 1'b0;
         data_out_q <= {DW{1'b0}};
         data_oe_q  <= 1'b0;
         echo_p_q   <= `BFS_ECHO_P_RST;
         echo_n_q   <= `BFS_ECHO_N_RST;
      end else begin
         dly_dq_q <= ob_dq_q;
         dly_oe_q <= ob_oe_q;
         if (!dll_off_n_s) begin
            data_out_q <= dly_dq_q;
            data_oe_q  <= dly_oe_q;
         end else begin
            data_out_q <= ob_dq_q;
            data_oe_q  <= ob_oe_q;
         end
         echo_p_q <= echo_p_pre_q;
         echo_n_q <= echo_n_pre_q;
      end
   end

   assign data_out   = data_out_q;
   assign data_oe    = data_oe_q;
   assign echo_clk_p = echo_p_q;
   assign echo_clk_n = echo_n_q;
endmodule // bfs_port

// File: test/bfs_port_monitor.sv
// Port checker for the burst-of-four SRAM port: echo clocks, output enable and read timing.
`timescale 1ns/1ps
module bfs_port_monitor #(
   parameter ORG = 36
) (
   input wire           mclk,
   input wire           rstn,
   input wire           input_clk_p,
   input wire           input_clk_n,
   input wire           output_clk_p,
   input wire           output_clk_n,
   input wire           dll_off_n,
   input wire           load_n,
   input wire           read_not_write,
   input wire [ORG-1:0] data_out,
   input wire           data_oe,
   input wire           echo_clk_p,
   input wire           echo_clk_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   logic [5:0] still_q;
   logic [5:0] rd_age_q;

   // Ages since the last echo change and since a read strobe stood on the pins.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         still_q  <= 6'h00;
         rd_age_q <= 6'h3f;
      end else begin
         still_q  <= $changed(echo_clk_p) ? 6'h00 : still_q + 6'h01;
         rd_age_q <= (!load_n && read_not_write) ? 6'h00 : rd_age_q + {5'h00, rd_age_q != 6'h3f};
      end
   end

   oe_reset_a: assert property (disable iff (1'b0) !rstn |-> !data_oe)
      else $error("data pins driven during reset");
   echo_compl_a: assert property (echo_clk_p != echo_clk_n)
      else $error("echo clocks not complementary");
   echo_alive_a: assert property (still_q < 6'h20)
      else $error("echo clocks stopped");
   echo_p_src_a: assert property ($rose(echo_clk_p) |-> $past(input_clk_p, 2) || $past(output_clk_p, 2))
      else $error("positive echo rose without a positive clock");
   echo_n_src_a: assert property ($rose(echo_clk_n) |-> $past(input_clk_n, 2) || $past(output_clk_n, 2))
      else $error("negative echo rose without a negative clock");
   rd_cause_a: assert property ($rose(data_oe) |-> rd_age_q < 6'h18)
      else $error("data pins driven without a read command");
   oe_fall_a: assert property ($fell(data_oe) |-> echo_clk_p && !$past(echo_clk_p, 2))
      else $error("output enable dropped away from a positive edge");
   data_hold_a: assert property (data_oe && $past(data_oe) && $stable(echo_clk_p)
      && $past(echo_clk_p) == $past(echo_clk_p, 2) |-> $stable(data_out))
      else $error("read word changed between clock edges");
   dll_on_a: assert property ($rose(data_oe) && dll_off_n && $past(dll_off_n, 4) |-> $rose(echo_clk_p))
      else $error("first word not aligned with positive echo");
   dll_off_a: assert property ($rose(data_oe) && !dll_off_n && !$past(dll_off_n, 4)
      |-> $past(echo_clk_p) && !$past(echo_clk_p, 2))
      else $error("first word not one cycle behind positive echo");

   // Main scenarios reached.
   cover property ($rose(data_oe) && !dll_off_n);
   cover property ($rose(data_oe) && output_clk_p && output_clk_n);
   cover property ($fell(data_oe));
endmodule // bfs_port_monitor

bind bfs_port bfs_port_monitor #(.ORG(ORG)) bfs_port_monitor_i (
   .mclk(mclk), .rstn(rstn), .input_clk_p(input_clk_p), .input_clk_n(input_clk_n),
   .output_clk_p(output_clk_p), .output_clk_n(output_clk_n), .dll_off_n(dll_off_n),
   .load_n(load_n), .read_not_write(read_not_write), .data_out(data_out),
   .data_oe(data_oe), .echo_clk_p(echo_clk_p), .echo_clk_n(echo_clk_n));

// File: test/bfs_ctl_model.sv
// Controller model: link clocks, command and write burst driver, read word capture.
`timescale 1ns/1ps
module bfs_ctl_model (
   input  wire        mclk,
   output wire        input_clk_p,
   output wire        input_clk_n,
   output wire        output_clk_p,
   output wire        output_clk_n,
   output reg         load_n = 1'b1,
   output reg         read_not_write = 1'b0,
   output reg  [18:0] addr_in = 19'h0_0000,
   output reg  [3:0]  byte_mask_n = 4'hf,
   output wire [35:0] data_in,
   input  wire [35:0] data_out,
   input  wire        data_oe,
   input  wire        echo_clk_p
);
   reg         single_q = 1'b0;
   reg  [2:0]  ph_q = 3'h0;
   reg  [2:0]  eh_q = 3'h0;
   reg  [35:0] wd_q = 36'h0_0000_0000;
   reg  [35:0] rd_q [$];

   // Free running 200 ns link clock, stepped on falling mclk edges.
   always @(negedge mclk) ph_q <= ph_q + 3'h1;
   // Output clocks follow the input pair unless both are parked high.
   assign input_clk_p  = ~ph_q[2];
   assign input_clk_n  = ph_q[2];
   assign output_clk_p = single_q | ~ph_q[2];
   assign output_clk_n = single_q | ph_q[2];
   // Shared data wire: the device wins while it drives.
   assign data_in = data_oe ? data_out : wd_q;

   // Take each read word two cycles after the echo edge that launched it.
   always @(negedge mclk) begin
      eh_q <= {eh_q[1:0], echo_clk_p};
      if (eh_q[2] != eh_q[1] && data_oe === 1'b1) rd_q.push_back(data_out);
   end

   // Move just past the next falling mclk edges.
   task automatic step(input integer n);
      repeat (n) begin
         @(negedge mclk);
         #1;
      end
   endtask

   // Present a command two cycles before a K rise and hold it across that rise.
   task automatic cmd(input rd, input [18:0] a);
      integer i;
      step(1);
      for (i = 0; i < 8 && ph_q != 3'h6; i++) step(1);
      wd_q = ~wd_q;
      byte_mask_n = ~byte_mask_n;
      load_n = 1'b0;
      read_not_write = rd;
      addr_in = a;
      step(4);
      load_n = 1'b1;
      read_not_write = ~rd;
      addr_in = ~a;
   endtask

   // Write burst: words for the next K rise, then K-bar, K and K-bar.
   task automatic wr(input [18:0] a, input [143:0] w, input [15:0] m);
      integer i;
      cmd(1'b0, a);
      for (i = 0; i < 4; i++) begin
         step(4);
         wd_q = w[36*i +: 36];
         byte_mask_n = m[4*i +: 4];
      end
   endtask
endmodule // bfs_ctl_model

// File: test/testbench.sv
// Self-checking bench for the burst-of-four SRAM port driven by a controller model.
`timescale 1ns/1ps
module testbench;
   reg          mclk = 1'b0;
   reg          rstn = 1'b1;
   reg          dll_off_n = 1'b1;
   wire         input_clk_p, input_clk_n, output_clk_p, output_clk_n;
   wire         load_n, read_not_write, data_oe, echo_clk_p, echo_clk_n;
   wire [18:0]  addr_in;
   wire [3:0]   byte_mask_n;
   wire [35:0]  data_in, data_out;
   integer      err_count = 0;
   integer      n_compared = 0;
   reg  [35:0]  ref_q [0:63];

   // Bench clock, 25 ns period.
   always #12.5 mclk = ~mclk;

   bfs_port #(.ORG(36), .ROW_AW(4)) bfs_port_i (
      .mclk(mclk), .rstn(rstn), .input_clk_p(input_clk_p), .input_clk_n(input_clk_n),
      .output_clk_p(output_clk_p), .output_clk_n(output_clk_n), .dll_off_n(dll_off_n),
      .load_n(load_n), .read_not_write(read_not_write), .addr_in(addr_in),
      .byte_mask_n(byte_mask_n), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .echo_clk_p(echo_clk_p), .echo_clk_n(echo_clk_n));

   bfs_ctl_model bfs_ctl_model_i (
      .mclk(mclk), .input_clk_p(input_clk_p), .input_clk_n(input_clk_n),
      .output_clk_p(output_clk_p), .output_clk_n(output_clk_n), .load_n(load_n),
      .read_not_write(read_not_write), .addr_in(addr_in), .byte_mask_n(byte_mask_n),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .echo_clk_p(echo_clk_p));

   // Compare one value and count it.
   task automatic chk(input [35:0] got, input [35:0] exp);
      n_compared = n_compared + 1;
      // An unknown expectation is a hole in the reference, so it counts as a mismatch.
      if (got !== exp || ^exp === 1'bx) begin
         err_count = err_count + 1;
         $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // Print the counts and the verdict, then stop.
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Write a burst built from a seed and mirror its unmasked lanes in the reference.
   task automatic do_wr(input [5:0] a, input [35:0] s, input [15:0] m);
      reg [143:0] w;
      integer     i;
      integer     j;
      for (i = 0; i < 4; i++) w[36*i +: 36] = s + 36'h2_4689_1357 * i;
      bfs_ctl_model_i.wr({13'h0000, a}, w, m);
      for (i = 0; i < 4; i++)
         for (j = 0; j < 4; j++)
            if (!m[4*i+j]) ref_q[{a[5:2], a[1:0] + i[1:0]}][9*j +: 9] = w[36*i+9*j +: 9];
   endtask

   // Wait a bounded time for four read words and compare them in burst order.
   task automatic collect(input [5:0] a);
      integer i;
      for (i = 0; i < 80 && bfs_ctl_model_i.rd_q.size() < 4; i++) @(negedge mclk);
      chk(bfs_ctl_model_i.rd_q.size(), 36'h4);
      if (bfs_ctl_model_i.rd_q.size() < 4)
         wrap_up;
      else
         for (i = 0; i < 4; i++)
            chk(bfs_ctl_model_i.rd_q.pop_front(), ref_q[{a[5:2], a[1:0] + i[1:0]}]);
   endtask

   // Read after the write commit gap has passed.
   task automatic do_rd(input [5:0] a);
      repeat (8) @(negedge mclk);
      bfs_ctl_model_i.rd_q.delete();
      bfs_ctl_model_i.cmd(1'b1, {13'h0000, a});
      collect(a);
   endtask

   // Data pins idle after power-up and the echo clock toggles on every link edge.
   task automatic t_power;
      integer i;
      integer n;
      reg     p;
      n = 0;
      chk({35'h0, data_oe}, 36'h0);
      p = echo_clk_p;
      for (i = 0; i < 64; i++) begin
         @(negedge mclk);
         n = n + (echo_clk_p !== p);
         p = echo_clk_p;
      end
      chk(n, 36'h10);
      $display("t_power done");
   endtask

   // Back-to-back writes to two rows, then read both back.
   task automatic t_burst;
      do_wr(6'h04, 36'h1_0000_0001, 16'h0000);
      do_wr(6'h08, 36'h2_0000_0002, 16'h0000);
      do_rd(6'h04);
      do_rd(6'h08);
      $display("t_burst done");
   endtask

   // Bursts that start mid-row wrap within the four words.
   task automatic t_wrap;
      do_wr(6'h0e, 36'h3_0000_0003, 16'h0000);
      do_rd(6'h0d);
      $display("t_wrap done");
   endtask

   // Lane masks: two lanes, a whole word, none, and three lanes suppressed.
   task automatic t_mask;
      do_wr(6'h04, 36'h5_a5a5_a5a5, 16'he0f5);
      do_rd(6'h06);
      $display("t_mask done");
   endtask

   // A write at the rise right after a read is refused and changes nothing.
   task automatic t_refuse;
      bfs_ctl_model_i.rd_q.delete();
      bfs_ctl_model_i.cmd(1'b1, 19'h0_0008);
      bfs_ctl_model_i.cmd(1'b0, 19'h0_000c);
      collect(6'h08);
      do_rd(6'h0c);
      $display("t_refuse done");
   endtask

   // Same read in normal, single clock and loop-bypassed output modes.
   task automatic t_modes;
      integer k;
      for (k = 0; k < 3; k++) begin
         bfs_ctl_model_i.single_q = (k == 1);
         dll_off_n = (k != 2);
         repeat (16) @(negedge mclk);
         do_rd(6'h0d);
      end
      bfs_ctl_model_i.single_q = 1'b0;
      dll_off_n = 1'b1;
      $display("t_modes done");
   endtask

   // Main sequence; reset falls just after time zero so its edge reaches every register with an asynchronous reset.
   initial begin
      #1;
      rstn = 1'b0;
      repeat (12) @(negedge mclk);
      rstn = 1'b1;
      repeat (16) @(negedge mclk);
      t_power;
      t_burst;
      t_wrap;
      t_mask;
      t_refuse;
      t_modes;
      wrap_up;
   end
endmodule // testbench
